// [pkg/lbh_pkg.sv]
package lbh_pkg;

   // --------------------------------------------------------------------
   // Bus cycle status codes
   // --------------------------------------------------------------------
   localparam logic [2:0] CYC_INTA    = 3'h0;
   localparam logic [2:0] CYC_IO_RD   = 3'h1;
   localparam logic [2:0] CYC_IO_WR   = 3'h2;
   localparam logic [2:0] CYC_HALT    = 3'h3;
   localparam logic [2:0] CYC_FETCH   = 3'h4;
   localparam logic [2:0] CYC_MEM_RD  = 3'h5;
   localparam logic [2:0] CYC_MEM_WR  = 3'h6;
   localparam logic [2:0] CYC_PASSIVE = 3'h7;

   // --------------------------------------------------------------------
   // Field positions within a status code
   // --------------------------------------------------------------------
   localparam int CYC_MEM_BIT = 2;
   localparam int CYC_DIR_BIT = 1;

   // --------------------------------------------------------------------
   // Address map and timing
   // --------------------------------------------------------------------
   localparam int         ADDR_W         = 20;
   localparam int         UPPER_MIN_LOG2 = 10;
   localparam logic [3:0] UPPER_SEL_MAX  = 4'h8;
   localparam int         CYCLE_CLKS     = 4;
   localparam logic [1:0] SAMPLE_EDGE    = 2'h2;

   // --------------------------------------------------------------------
   // Reset values
   // --------------------------------------------------------------------
   localparam logic RST_OE     = 1'b0;
   localparam logic RST_SEL_N  = 1'b1;
   localparam logic RST_SYNC   = 1'b1;

   typedef enum logic [1:0]
   {
      LBH_IDLE,
      LBH_CYCLE,
      LBH_HOLD,
      LBH_FLOAT
   } lbh_state_e;

endpackage

// [logic/lbh_sync2.sv]
`timescale 1ns/1ps

module lbh_sync2
   import lbh_pkg::*;
#(
   parameter int WIDTH = 3
)
(
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_r;

   // --------------------------------------------------------------------
   // Two stage synchroniser
   // --------------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_r   <= {WIDTH{RST_SYNC}};
         sync_out <= {WIDTH{RST_SYNC}};
      end
      else
      begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end

endmodule

// [logic/lbh_bus_owner.sv]
`timescale 1ns/1ps

// Operation
// [R1] Drive active-low bus exclusive output.
// [R2] Lock starts at first following data cycle.
// [R3] Lock holds until locked instruction completes.
// [R4] No prefetch cycles while lock asserted.
// [R5] Lock floats during hold and reset.
// [R6] Three active-low status lines encode cycle type.
// [R7] Codes 000..111 in listed order, 111 passive.
// [R8] Top bit memory/IO, middle bit direction.
// [R9] Master holds request high while needing bus.
// [R10] Grant high and float bus together.
// [R11] Grant drops after request seen low.
// [R12] Drive bus again only for next cycle.
// [R13] Enhanced: grant drops when refresh pending.
// [R14] Master then lowers request for refresh.
// [R15] Upper select for references in upper block.
// [R16] Upper select keeps driving during hold.
// [R17] Both selects low at reset release: test float.
// [R18] Test float floats all outputs until reset.

module lbh_bus_owner
   import lbh_pkg::*;
#(
   parameter int CYC_CLKS = CYCLE_CLKS
)
(
   input  wire logic              clock,
   input  wire logic              rst_n,
   input  wire logic              hold_req_in,
   input  wire logic              upper_mem_select_in,
   input  wire logic              lower_mem_select_in,
   input  wire logic              enhanced_mode,
   input  wire logic              refresh_pending,
   input  wire logic              cycle_req,
   input  wire logic [2:0]        cycle_type,
   input  wire logic [ADDR_W-1:0] cycle_addr,
   input  wire logic              cycle_is_prefetch,
   input  wire logic              lock_prefix,
   input  wire logic              locked_instr_done,
   input  wire logic [3:0]        upper_size_sel,
   output logic                   cycle_ack,
   output logic                   cycle_done,
   output logic                   bus_lock_n,
   output logic                   bus_lock_oe,
   output logic                   cycle_status_bit0_n,
   output logic                   cycle_status_bit1_n,
   output logic                   cycle_status_bit2_n,
   output logic                   cycle_status_oe,
   output logic                   transceiver_direction,
   output logic                   transceiver_direction_oe,
   output logic                   bus_ctrl_oe,
   output logic                   bus_grant_out,
   output logic                   bus_grant_oe,
   output logic                   upper_mem_select_n,
   output logic                   upper_mem_select_oe,
   output logic                   test_float_mode
);

   localparam logic [3:0] CYC_LAST = 4'(CYC_CLKS - 1);

   // --------------------------------------------------------------------
   // Decode helpers
   // --------------------------------------------------------------------
   function automatic logic is_data_cycle(input logic [2:0] t);
      is_data_cycle = (t == CYC_IO_RD) || (t == CYC_IO_WR) ||
                      (t == CYC_MEM_RD) || (t == CYC_MEM_WR);
   endfunction

   function automatic logic is_mem_ref(input logic [2:0] t);
      is_mem_ref = t[CYC_MEM_BIT] && (t != CYC_PASSIVE);
   endfunction

   function automatic logic in_upper(input logic [ADDR_W-1:0] a, input logic [3:0] sel);
      logic [ADDR_W-1:0] mask;
      logic [3:0]        s;
      mask = '0;
      s    = (sel > UPPER_SEL_MAX) ? UPPER_SEL_MAX : sel;
      mask = ~((ADDR_W'(1) << (UPPER_MIN_LOG2 + int'(s))) - ADDR_W'(1));
      in_upper = ((a & mask) == mask);
   endfunction

   // --------------------------------------------------------------------
   // Pin synchronisers
   // --------------------------------------------------------------------
   logic [2:0] pins_s;
   wire        hold_s = pins_s[0];
   wire        ucs_s  = pins_s[1];
   wire        lcs_s  = pins_s[2];

   lbh_sync2 #(.WIDTH(3)) u_sync
   (
      .clock    (clock),
      .rst_n    (rst_n),
      .async_in ({lower_mem_select_in, upper_mem_select_in, hold_req_in}),
      .sync_out (pins_s)
   );

   // --------------------------------------------------------------------
   // State
   // --------------------------------------------------------------------
   lbh_state_e        state_r;
   lbh_state_e        state_nxt;
   logic [1:0]        samp_cnt_r;
   logic              running_r;
   logic              test_float_mode_r;
   logic [3:0]        cnt_r;
   logic [2:0]        cur_type_r;
   logic [ADDR_W-1:0] cur_addr_r;
   logic              lock_r;
   logic              lock_pend_r;
   logic              lock_n_r;
   logic              grant_oe_r;
   logic [2:0]        status_r;
   logic              dir_r;
   logic              drive_r;
   logic              grant_r;
   logic              ucs_n_r;
   logic              ucs_oe_r;
   logic              ack_r;
   logic              done_r;

   // --------------------------------------------------------------------
   // Sequencing decode
   // --------------------------------------------------------------------
   wire live       = running_r && !test_float_mode_r;
   wire can_start  = live && ((state_r == LBH_IDLE) || (state_r == LBH_FLOAT));
   wire take_hold  = can_start && hold_s && !lock_r;
   wire accept     = can_start && !take_hold && cycle_req &&
                     !(cycle_is_prefetch && lock_r); // [R4]
   wire lock_start = accept && lock_pend_r && is_data_cycle(cycle_type); // [R2]
   wire cyc_end    = (state_r == LBH_CYCLE) && (cnt_r == 4'h0);
   wire cyc_cont   = (state_r == LBH_CYCLE) && !cyc_end;
   wire refresh_rq = enhanced_mode && refresh_pending;
   wire lock_nxt   = lock_start || (lock_r && !locked_instr_done); // [R3]

   wire [2:0]        type_nxt = accept ? cycle_type : cur_type_r;
   wire [ADDR_W-1:0] addr_nxt = accept ? cycle_addr : cur_addr_r;
   wire              busy_nxt = accept || cyc_cont;
   wire [2:0]        status_nxt = busy_nxt ? type_nxt : CYC_PASSIVE; // [R6] [R7]
   wire              dir_nxt = busy_nxt && type_nxt[CYC_DIR_BIT]; // [R8]
   wire              ucs_hit = busy_nxt && is_mem_ref(type_nxt) &&
                               in_upper(addr_nxt, upper_size_sel); // [R15]
   wire              grant_nxt = live && (take_hold || ((state_r == LBH_HOLD) && grant_r &&
                                 hold_s && !refresh_rq)); // [R10] [R11] [R13]
   wire              drive_nxt = live && ((state_nxt == LBH_IDLE) ||
                                 (state_nxt == LBH_CYCLE)); // [R10] [R12]

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         LBH_IDLE, LBH_FLOAT:
         begin
            if (take_hold)
               state_nxt = LBH_HOLD;
            else if (accept)
               state_nxt = LBH_CYCLE;
         end
         LBH_CYCLE:
         begin
            if (cyc_end)
               state_nxt = LBH_IDLE;
         end
         LBH_HOLD:
         begin
            if (!hold_s)
               state_nxt = LBH_FLOAT; // [R12]
         end
         default:
            state_nxt = LBH_IDLE;
      endcase
      if (!live)
         state_nxt = LBH_IDLE;
   end

   // --------------------------------------------------------------------
   // Reset strap sampling
   // --------------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         samp_cnt_r <= 2'h0;
         running_r  <= 1'b0;
         test_float_mode_r     <= 1'b0;
         grant_oe_r <= 1'b0;
      end
      else if (!running_r)
      begin
         samp_cnt_r <= samp_cnt_r + 2'h1;
         if (samp_cnt_r == SAMPLE_EDGE)
         begin
            running_r <= 1'b1;
            test_float_mode_r    <= !ucs_s && !lcs_s; // [R17]
            grant_oe_r <= ucs_s || lcs_s; // [R18]
         end
      end
   end

   // --------------------------------------------------------------------
   // Cycle engine and lock
   // --------------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r     <= LBH_IDLE;
         cnt_r       <= 4'h0;
         cur_type_r  <= CYC_PASSIVE;
         cur_addr_r  <= '0;
         lock_r      <= 1'b0;
         lock_pend_r <= 1'b0;
         lock_n_r    <= 1'b1;
         ack_r       <= 1'b0;
         done_r      <= 1'b0;
      end
      else
      begin
         state_r     <= state_nxt;
         cnt_r       <= accept ? CYC_LAST : (cyc_cont ? cnt_r - 4'h1 : cnt_r);
         cur_type_r  <= type_nxt;
         cur_addr_r  <= addr_nxt;
         lock_r      <= lock_nxt;
         lock_pend_r <= lock_prefix || (lock_pend_r && !lock_start);
         lock_n_r    <= !lock_nxt;
         ack_r       <= accept;
         done_r      <= cyc_end;
      end
   end

   // --------------------------------------------------------------------
   // Output pins
   // --------------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         status_r <= CYC_PASSIVE;
         dir_r    <= 1'b0;
         drive_r  <= RST_OE;
         grant_r  <= 1'b0;
         ucs_n_r  <= RST_SEL_N;
         ucs_oe_r <= RST_OE;
      end
      else
      begin
         status_r <= status_nxt;
         dir_r    <= dir_nxt;
         drive_r  <= drive_nxt; // [R5] [R18]
         grant_r  <= grant_nxt;
         ucs_n_r  <= !ucs_hit;
         ucs_oe_r <= live; // [R16] [R18]
      end
   end

   assign cycle_ack                = ack_r;
   assign cycle_done               = done_r;
   assign bus_lock_n               = lock_n_r; // [R1]
   assign bus_lock_oe              = drive_r; // [R5]
   assign cycle_status_bit0_n      = status_r[0];
   assign cycle_status_bit1_n      = status_r[1];
   assign cycle_status_bit2_n      = status_r[2];
   assign cycle_status_oe          = drive_r;
   assign transceiver_direction    = dir_r;
   assign transceiver_direction_oe = drive_r;
   assign bus_ctrl_oe              = drive_r;
   assign bus_grant_out            = grant_r;
   assign bus_grant_oe             = grant_oe_r; // [R18]
   assign upper_mem_select_n       = ucs_n_r;
   assign upper_mem_select_oe      = ucs_oe_r;
   assign test_float_mode          = test_float_mode_r;

   // --------------------------------------------------------------------
   // Assertions
   // --------------------------------------------------------------------
   sequence s_lock_begin;
      lock_start ##1 !bus_lock_n;
   endsequence

   sequence s_cycle_begin;
      accept ##1 (status_r == $past(cycle_type));
   endsequence

   a_lock_start: assert property (@(posedge clock) disable iff (!rst_n) // [R2]
      lock_start |-> s_lock_begin) else $error("lock not raised at data cycle");
   a_lock_release: assert property (@(posedge clock) disable iff (!rst_n) // [R3]
      $rose(bus_lock_n) |-> $past(locked_instr_done)) else $error("lock dropped early");
   a_no_prefetch: assert property (@(posedge clock) disable iff (!rst_n) // [R4]
      (cycle_ack && !$past(bus_lock_n)) |-> !$past(cycle_is_prefetch))
      else $error("prefetch under lock");
   a_lock_float: assert property (@(posedge clock) disable iff (!rst_n) // [R5]
      bus_grant_out |-> !bus_lock_oe) else $error("lock driven during hold");
   a_status_code: assert property (@(posedge clock) disable iff (!rst_n) // [R6]
      accept |-> s_cycle_begin) else $error("status code mismatch");
   a_status_idle: assert property (@(posedge clock) disable iff (!rst_n) // [R7]
      cyc_end |=> (status_r == CYC_PASSIVE) [*1]) else $error("status not passive");
   a_dir_bit: assert property (@(posedge clock) disable iff (!rst_n) // [R8]
      (status_r != CYC_PASSIVE) |-> (transceiver_direction == status_r[CYC_DIR_BIT]))
      else $error("direction mismatch");
   a_grant_float: assert property (@(posedge clock) disable iff (!rst_n) // [R10]
      take_hold |=> bus_grant_out && !bus_ctrl_oe && !cycle_status_oe)
      else $error("grant without float");
   a_grant_drop: assert property (@(posedge clock) disable iff (!rst_n) // [R11]
      ((state_r == LBH_HOLD) && !hold_s) |=> !bus_grant_out) else $error("grant stuck");
   a_float_wait: assert property (@(posedge clock) disable iff (!rst_n) // [R12]
      ((state_r == LBH_FLOAT) && !accept) |=> !bus_ctrl_oe) else $error("bus driven early");
   a_refresh_drop: assert property (@(posedge clock) disable iff (!rst_n) // [R13]
      ((state_r == LBH_HOLD) && refresh_rq) |=> !bus_grant_out [*2])
      else $error("grant kept with refresh");
   a_ucs_hold: assert property (@(posedge clock) disable iff (!rst_n) // [R16]
      bus_grant_out |-> upper_mem_select_oe) else $error("upper select floated");
   a_test_float_mode_float: assert property (@(posedge clock) disable iff (!rst_n) // [R18]
      test_float_mode |-> !upper_mem_select_oe && !bus_ctrl_oe && !bus_grant_oe)
      else $error("output driven in test float");

endmodule

// [testbench/lbh_master_model.sv]
`timescale 1ns/1ps

// ----------------------------------------------------------------
// External bus master asking for the local bus
// ----------------------------------------------------------------
module lbh_master_model
(
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       want,
   input  wire logic [3:0] lag,
   input  wire logic       bus_grant_out,
   output logic            hold_req_in
);
   logic       had_r;
   logic [3:0] cnt_r;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hold_req_in <= 1'b0;
         had_r <= 1'b0;
         cnt_r <= 4'h0;
      end
      else if (!want)
      begin
         hold_req_in <= 1'b0;
         had_r <= 1'b0;
      end
      else if (bus_grant_out)
         had_r <= 1'b1;
      else if (had_r && hold_req_in)
      begin
         cnt_r <= cnt_r + 4'h1;
         if (cnt_r >= lag)
            hold_req_in <= 1'b0;
      end
      else if (!had_r)
      begin
         hold_req_in <= 1'b1;
         cnt_r <= 4'h0;
      end
   end
endmodule

// [testbench/tb_top.sv]
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
   begin \
      comparisons++; \
      if ((gt) !== (ex)) \
      begin \
         fails++; \
         $display("MISMATCH %s exp %h got %h", nm, ex, gt); \
      end \
   end

module tb_top
   import lbh_pkg::*;
;
   logic              clock, rst_n, hold_req_in, upper_mem_select_in, lower_mem_select_in;
   logic              enhanced_mode, refresh_pending, cycle_req, cycle_is_prefetch;
   logic              lock_prefix, locked_instr_done, want, strap_low;
   logic [2:0]        cycle_type;
   logic [ADDR_W-1:0] cycle_addr, ad;
   logic [3:0]        upper_size_sel, lag;
   logic              cycle_ack, cycle_done, bus_lock_n, bus_lock_oe, cycle_status_oe;
   logic              cycle_status_bit0_n, cycle_status_bit1_n, cycle_status_bit2_n;
   logic              transceiver_direction, transceiver_direction_oe, bus_ctrl_oe;
   logic              bus_grant_out, bus_grant_oe, upper_mem_select_n, upper_mem_select_oe;
   logic              test_float_mode;
   logic [4:0]        exp_q[$];
   logic [4:0]        mon_e;
   int                fails, comparisons;
   wire [2:0]         status_seen = {cycle_status_bit2_n, cycle_status_bit1_n,
                                     cycle_status_bit0_n};
   wire [5:0]         oe_seen = {bus_ctrl_oe, cycle_status_oe, bus_lock_oe,
                                 transceiver_direction_oe, bus_grant_oe, upper_mem_select_oe};

   // Select wires carry pull-ups; the strap pulls both low.
   assign upper_mem_select_in = strap_low ? 1'b0 :
                                (upper_mem_select_oe ? upper_mem_select_n : 1'b1);
   assign lower_mem_select_in = !strap_low;

   lbh_bus_owner #(.CYC_CLKS(2)) uut
   (
      .clock, .rst_n, .hold_req_in, .upper_mem_select_in, .lower_mem_select_in,
      .enhanced_mode, .refresh_pending, .cycle_req, .cycle_type, .cycle_addr,
      .cycle_is_prefetch, .lock_prefix, .locked_instr_done, .upper_size_sel,
      .cycle_ack, .cycle_done, .bus_lock_n, .bus_lock_oe, .cycle_status_bit0_n,
      .cycle_status_bit1_n, .cycle_status_bit2_n, .cycle_status_oe,
      .transceiver_direction, .transceiver_direction_oe, .bus_ctrl_oe,
      .bus_grant_out, .bus_grant_oe, .upper_mem_select_n, .upper_mem_select_oe,
      .test_float_mode
   );

   lbh_master_model master (.clock, .rst_n, .want, .lag, .bus_grant_out, .hold_req_in);

   initial
   begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic wrap_up;
      if (fails == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic wait_for(ref logic s, input logic v, input string nm);
      int i;
      i = 0;
      while (s !== v && i < 40)
      begin
         cyc(1);
         i++;
      end
      `CHK(nm, v, s)
   endtask

   task automatic quiet(ref logic s, input logic v, input int n, input string nm);
      repeat (n)
      begin
         cyc(1);
         `CHK(nm, v, s)
      end
   endtask

   function automatic logic exp_ucs(logic [2:0] t, logic [ADDR_W-1:0] a, logic [3:0] sel);
      logic [3:0] s;
      s = (sel > 4'h8) ? 4'h8 : sel;
      return !(t >= CYC_FETCH && t <= CYC_MEM_WR && {1'b0, a} >= 21'h100000 - (21'h400 << s));
   endfunction

   task automatic req_start(input logic [2:0] t, input logic [ADDR_W-1:0] a, input logic pf,
                            input logic lk);
      cycle_type = t;
      cycle_addr = a;
      cycle_is_prefetch = pf;
      cycle_req = 1'b1;
      exp_q.push_back({lk, exp_ucs(t, a, upper_size_sel), t});
   endtask

   task automatic req_finish;
      wait_for(cycle_ack, 1'b1, "cycle_ack");
      cycle_req = 1'b0;
      wait_for(cycle_done, 1'b1, "cycle_done");
   endtask

   task automatic do_reset(input logic s);
      rst_n = 1'b0;
      strap_low = s;
      cycle_req = 1'b0;
      want = 1'b0;
      exp_q.delete();
      repeat (10) @(posedge clock);
      #1;
      `CHK("lock_oe_rst", 1'b0, bus_lock_oe)
      rst_n = 1'b1;
      cyc(5);
      strap_low = 1'b0;
   endtask

   // ----------------------------------------------------------------
   // Result monitor
   // ----------------------------------------------------------------
   always @(posedge clock)
   begin
      #1;
      if (cycle_ack === 1'b1)
      begin
         mon_e = exp_q.size() ? exp_q.pop_front() : 5'hxx;
         `CHK("status", mon_e[2:0], status_seen)
         `CHK("direction", mon_e[1], transceiver_direction)
         `CHK("upper_sel", mon_e[3], upper_mem_select_n)
         `CHK("lock", mon_e[4], bus_lock_n)
         `CHK("bus_ctrl_oe", 1'b1, bus_ctrl_oe)
      end
   end

   initial
   begin
      #20000;
      fails++;
      wrap_up;
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      {rst_n, strap_low, enhanced_mode, refresh_pending, cycle_req, cycle_is_prefetch} = 6'h00;
      {lock_prefix, locked_instr_done, want, cycle_type, lag} = 10'h000;
      cycle_addr = 20'h00000;
      upper_size_sel = 4'h8;
      fails = 0;
      comparisons = 0;
      void'($urandom(98));
      do_reset(1'b0);
      for (int k = 0; k < 16; k++)
      begin
         upper_size_sel = k[3] ? {4{k[2]}} : 4'($urandom % 16);
         ad = k[3] ? (k[2] ? (k[0] ? 20'hc0000 : 20'hbffff) : (k[0] ? 20'hffc00 : 20'hffbff))
                   : 20'($urandom);
         req_start(k[3] ? {1'b1, k[1:0]} : k[2:0], ad, 1'b0, 1'b1);
         req_finish;
      end
      lock_prefix = 1'b1;
      cyc(1);
      lock_prefix = 1'b0;
      req_start(CYC_FETCH, 20'hfff00, 1'b0, 1'b1);
      req_finish;
      req_start(CYC_IO_RD, 20'h00200, 1'b0, 1'b0);
      req_finish;
      want = 1'b1;
      req_start(CYC_FETCH, 20'hfff02, 1'b1, 1'b1);
      quiet(cycle_ack, 1'b0, 6, "prefetch_ack");
      quiet(bus_lock_n, 1'b0, 2, "lock_held");
      quiet(bus_grant_out, 1'b0, 2, "grant_in_lock");
      locked_instr_done = 1'b1;
      cyc(1);
      locked_instr_done = 1'b0;
      wait_for(bus_grant_out, 1'b1, "grant");
      `CHK("float", 4'h0, oe_seen[5:2])
      `CHK("ucs_oe", 1'b1, upper_mem_select_oe)
      quiet(cycle_ack, 1'b0, 4, "ack_in_hold");
      want = 1'b0;
      wait_for(bus_grant_out, 1'b0, "grant_drop");
      req_finish;
      enhanced_mode = 1'b1;
      lag = 4'h3;
      want = 1'b1;
      wait_for(bus_grant_out, 1'b1, "grant");
      refresh_pending = 1'b1;
      wait_for(bus_grant_out, 1'b0, "refresh_drop");
      quiet(bus_grant_out, 1'b0, 8, "grant_refresh");
      `CHK("bus_ctrl_oe", 1'b0, bus_ctrl_oe)
      {want, refresh_pending, enhanced_mode} = 3'h0;
      quiet(bus_ctrl_oe, 1'b0, 4, "bus_ctrl_oe");
      req_start(CYC_MEM_WR, 20'($urandom), 1'b0, 1'b1);
      req_finish;
      want = 1'b1;
      wait_for(bus_grant_out, 1'b1, "grant");
      refresh_pending = 1'b1;
      quiet(bus_grant_out, 1'b1, 6, "grant_compat");
      {want, refresh_pending} = 2'h0;
      wait_for(bus_grant_out, 1'b0, "grant_drop");
      do_reset(1'b1);
      `CHK("test_float", 1'b1, test_float_mode)
      cycle_req = 1'b1;
      quiet(cycle_ack, 1'b0, 6, "float_ack");
      cycle_req = 1'b0;
      `CHK("float_oe", 6'h00, oe_seen)
      do_reset(1'b0);
      `CHK("test_float", 1'b0, test_float_mode)
      req_start(CYC_MEM_RD, 20'hfffff, 1'b0, 1'b1);
      req_finish;
      wrap_up;
   end
endmodule
